// ### sea_nvm_port.sv
// Main file: APB registers and serial bus engine for the NVM access port
// Behaviour
// - Setting start bit launches one memory cycle
// - Command bit picks read (0) or write (1)
// - Missing acknowledge sets the error flag
// - Load success flag, cleared when software reads
// - Load status flag shows load outcome
// - Disable bit suppresses load, resets set
// - Rate field divides core clock by 1024, or by 4 with test code 11b
// - Word address field feeds the cycle
// - Data field sent; read result lands there
// - All fields packed in one word at BCh
// - Enabled load copies memory into config words
`timescale 1ns/1ns
module sea_nvm_port #(
  parameter int NCFG = 4 // Config words copied by the load
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Serial memory pins
  output sea_pkg::sea_pin_s          mem_pin,
  input  wire logic                  sda_i,
  // Interrupt and loaded configuration
  output logic                       irq,
  output logic [NCFG-1:0][15:0]      cfg_words
);

  // Load index is seven bits wide, matching the word address field
  if (NCFG < 1 || NCFG > 128) begin : g_bad_ncfg
    $error("NCFG out of range");
  end

  sea_pkg::sea_ctrl_s            ctrl_ff;
  sea_pkg::sea_ctrl_s            nxt_ctrl;
  sea_pkg::sea_st_e              st_ff;
  logic [1:0]                    ph_ff;
  logic [3:0]                    bcnt_ff;
  logic [2:0]                    bidx_ff;
  logic [7:0]                    sh_ff;
  logic [15:0]                   rx_ff;
  logic                          rd_ff;
  logic                          samp_ff;
  logic                          nack_ff;
  logic                          al_pend_ff;
  logic                          al_busy_ff;
  logic [6:0]                    al_idx_ff;
  logic [NCFG-1:0][15:0]         cfg_ff;
  logic [sea_pkg::SEA_STS_W-1:0] sts_ff;
  logic [sea_pkg::SEA_STS_W-1:0] msk_ff;
  logic [sea_pkg::SEA_STS_W-1:0] sts_set;
  logic [31:0]                   prdata_ff;
  logic                          pready_ff;
  logic                          pslverr_ff;
  logic                          irq_ff;
  sea_pkg::sea_pin_s             pin_ff;
  sea_pkg::sea_pin_s             nxt_pin;
  logic                          tick;

  // APB decode: one wait state, registered answer
  wire logic acc      = psel && penable;
  wire logic nxt_rdy  = acc && !pready_ff;
  wire logic commit   = acc && pready_ff;
  wire logic sel_ctrl = (paddr == sea_pkg::SEA_OFS_CTRL);
  wire logic sel_sts  = (paddr == sea_pkg::SEA_OFS_STS);
  wire logic sel_msk  = (paddr == sea_pkg::SEA_OFS_MSK);
  wire logic unmapped = !(sel_ctrl || sel_sts || sel_msk);
  wire logic wr_ctrl  = commit && pwrite && sel_ctrl;
  wire logic rd_ctrl  = commit && !pwrite && sel_ctrl;
  wire logic wr_sts   = commit && pwrite && sel_sts;
  wire logic wr_msk   = commit && pwrite && sel_msk;

  // Read mux; reserved bits read as zero
  wire logic [31:0] rd_mux =
    sel_ctrl ? (32'(ctrl_ff) & ~32'h0000_0100) :
    sel_sts  ? 32'(sts_ff) :
    sel_msk  ? 32'(msk_ff) : 32'h0000_0000;

  // Engine status terms
  wire logic idle     = (st_ff == sea_pkg::SEA_ST_IDLE);
  wire logic busy     = !idle || al_busy_ff || ctrl_ff.start;
  wire logic ph_last  = tick && (ph_ff == 2'h3);
  wire logic cyc_end  = (st_ff == sea_pkg::SEA_ST_STOP) && ph_last;
  wire logic man_end  = cyc_end && !al_busy_ff;
  wire logic al_end1  = cyc_end && al_busy_ff;
  wire logic al_last  = (al_idx_ff == 7'(NCFG - 1));
  wire logic load_end = al_end1 && (nack_ff || al_last);
  wire logic load_ok  = load_end && !nack_ff;
  wire logic man_go   = idle && ctrl_ff.start && !al_busy_ff;
  wire logic al_go    = idle && al_busy_ff;
  wire logic launch   = man_go || al_go;
  wire logic al_begin = al_pend_ff && !ctrl_ff.al_dis && !busy;
  wire logic run      = !idle;

  // Cycle source: load reads from its own index, manual from the fields
  wire logic [6:0]  cyc_addr = al_busy_ff ? al_idx_ff : ctrl_ff.addr;
  wire logic        go_rd    = al_busy_ff || !ctrl_ff.cmd;
  wire logic [7:0]  dev_w    = {sea_pkg::SEA_DEV_ADDR, 1'b0};
  wire logic [7:0]  dev_r    = {sea_pkg::SEA_DEV_ADDR, 1'b1};
  wire logic        slot_rx  = rd_ff && (bidx_ff >= sea_pkg::SEA_IDX_RD0);
  wire logic        slot_end = rd_ff ? (bidx_ff == sea_pkg::SEA_IDX_REND)
                                     : (bidx_ff == sea_pkg::SEA_IDX_WEND);
  wire logic        ack_bit  = (bcnt_ff == sea_pkg::SEA_ACK_BIT);
  wire logic        restart  = rd_ff && (bidx_ff == sea_pkg::SEA_IDX_ADDR);
  wire logic [2:0]  bidx_nx  = bidx_ff + 3'h1;
  wire logic [7:0]  next_tx  =
    (bidx_nx == 3'h1) ? {1'b0, cyc_addr} :
    (bidx_nx == 3'h2) ? ctrl_ff.data[15:8] :
                        ctrl_ff.data[7:0];

  // Tick divider for the memory clock
  sea_tick_div #(
    .DIV (sea_pkg::SEA_CORE_DIV)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .rate    (ctrl_ff.rate),
    .tick    (tick)
  );

  // Next control word: software fields, completion and load outcome
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl && !busy) begin
      nxt_ctrl.start  = pwdata[0];
      nxt_ctrl.cmd    = pwdata[1];
      nxt_ctrl.al_dis = pwdata[5];
      nxt_ctrl.rate   = pwdata[7:6];
      nxt_ctrl.addr   = pwdata[15:9];
      nxt_ctrl.data   = pwdata[31:16];
    end
    if (man_go) begin
      nxt_ctrl.err = 1'b0;
    end
    if (rd_ctrl) begin
      nxt_ctrl.al_succ = 1'b0;
    end
    if (load_ok) begin
      nxt_ctrl.al_succ = 1'b1;
      nxt_ctrl.al_stat = 1'b1;
    end
    if (man_end) begin
      nxt_ctrl.start = 1'b0;
      nxt_ctrl.err   = nack_ff;
      if (rd_ff && !nack_ff) begin // Refused read keeps the old data
        nxt_ctrl.data = rx_ff;
      end
    end
  end

  // Pin drive for the phase now running; open-drain data line
  always_comb begin
    nxt_pin       = '0;
    nxt_pin.scl   = 1'b1;
    case (st_ff)
      sea_pkg::SEA_ST_START: begin
        nxt_pin.scl    = (ph_ff == 2'h1) || (ph_ff == 2'h2);
        nxt_pin.sda_oe = ph_ff[1];
      end
      sea_pkg::SEA_ST_BIT: begin
        nxt_pin.scl    = (ph_ff == 2'h1) || (ph_ff == 2'h2);
        nxt_pin.sda_oe = slot_rx ? (ack_bit && !slot_end)
                                 : (!ack_bit && !sh_ff[7]);
      end
      sea_pkg::SEA_ST_STOP: begin
        nxt_pin.scl    = (ph_ff != 2'h0);
        nxt_pin.sda_oe = !ph_ff[1];
      end
      default: begin
        nxt_pin.scl = 1'b1;
      end
    endcase
  end

  // Control word, APB answer, pins and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= sea_pkg::SEA_CTRL_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      pin_ff     <= '{scl: 1'b1, sda_o: 1'b0, sda_oe: 1'b0};
      irq_ff     <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      pready_ff  <= nxt_rdy;
      if (nxt_rdy) begin
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_ff <= unmapped;
      end
      pin_ff     <= nxt_pin;
      irq_ff     <= |(sts_ff & msk_ff);
    end
  end

  // Sticky events; a set in the clearing cycle wins
  assign sts_set[sea_pkg::SEA_STS_DONE] = man_end;
  assign sts_set[sea_pkg::SEA_STS_ERR]  = cyc_end && nack_ff;
  assign sts_set[sea_pkg::SEA_STS_LOAD] = load_end;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_ff <= '0;
      msk_ff <= '0;
    end else begin
      sts_ff <= (sts_ff & ~(wr_sts ? pwdata[2:0] : 3'h0)) | sts_set;
      if (wr_msk) begin
        msk_ff <= pwdata[2:0];
      end
    end
  end

  // Serial engine: start, nine-bit byte slots with acknowledge, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff   <= sea_pkg::SEA_ST_IDLE;
      ph_ff   <= 2'h0;
      bcnt_ff <= 4'h0;
      bidx_ff <= 3'h0;
      sh_ff   <= 8'h00;
      rx_ff   <= 16'h0000;
      rd_ff   <= 1'b0;
      samp_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else if (launch) begin
      st_ff   <= sea_pkg::SEA_ST_START;
      ph_ff   <= 2'h0;
      bidx_ff <= 3'h0;
      sh_ff   <= dev_w;
      rd_ff   <= go_rd;
      nack_ff <= 1'b0;
    end else if (tick) begin
      ph_ff <= ph_ff + 2'h1;
      if (st_ff == sea_pkg::SEA_ST_BIT && ph_ff == 2'h2) begin
        samp_ff <= sda_i;
        if (slot_rx && !ack_bit) begin
          rx_ff <= {rx_ff[14:0], sda_i};
        end
      end
      if (ph_ff == 2'h3) begin
        case (st_ff)
          sea_pkg::SEA_ST_START: begin
            st_ff   <= sea_pkg::SEA_ST_BIT;
            bcnt_ff <= 4'h0;
          end
          sea_pkg::SEA_ST_BIT: begin
            if (!ack_bit) begin
              bcnt_ff <= bcnt_ff + 4'h1;
              sh_ff   <= {sh_ff[6:0], 1'b0};
            end else if (!slot_rx && samp_ff) begin
              nack_ff <= 1'b1;
              st_ff   <= sea_pkg::SEA_ST_STOP;
            end else if (slot_end) begin
              st_ff   <= sea_pkg::SEA_ST_STOP;
            end else if (restart) begin
              st_ff   <= sea_pkg::SEA_ST_START;
              bidx_ff <= bidx_nx;
              sh_ff   <= dev_r;
            end else begin
              bidx_ff <= bidx_nx;
              bcnt_ff <= 4'h0;
              sh_ff   <= next_tx;
            end
          end
          sea_pkg::SEA_ST_STOP: begin
            st_ff <= sea_pkg::SEA_ST_IDLE;
          end
          default: begin
            st_ff <= sea_pkg::SEA_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Reset-time load sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_pend_ff <= 1'b1;
      al_busy_ff <= 1'b0;
      al_idx_ff  <= 7'h00;
    end else begin
      if (man_go) begin
        al_pend_ff <= 1'b0;
      end
      if (al_begin) begin
        al_pend_ff <= 1'b0;
        al_busy_ff <= 1'b1;
        al_idx_ff  <= 7'h00;
      end else if (load_end) begin
        al_busy_ff <= 1'b0;
      end else if (al_end1) begin
        al_idx_ff  <= al_idx_ff + 7'h01;
      end
    end
  end

  // Loaded configuration words, one register per entry
  for (genvar i = 0; i < NCFG; i++) begin : g_cfg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_ff[i] <= 16'h0000;
      end else if (al_end1 && !nack_ff && al_idx_ff == 7'(i)) begin
        cfg_ff[i] <= rx_ff;
      end
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign mem_pin   = pin_ff;
  assign irq       = irq_ff;
  assign cfg_words = cfg_ff;

  // Checks on the block's own outputs and state
  start_begins_a: assert property (@(posedge pclk) disable iff (!presetn)
    man_go |=> (st_ff == sea_pkg::SEA_ST_START) ##1 ctrl_ff.start)
    else $error("manual cycle did not launch");
  read_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    man_go |=> (rd_ff == !$past(ctrl_ff.cmd)))
    else $error("direction not taken from command bit");
  nack_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (man_end && nack_ff) |=> ctrl_ff.err && sts_ff[sea_pkg::SEA_STS_ERR])
    else $error("missing acknowledge not flagged");
  succ_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_ctrl && !load_ok) |=> !ctrl_ff.al_succ)
    else $error("success flag not cleared by read");
  load_stat_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_ff.al_stat) |-> $past(load_end) && !$past(nack_ff))
    else $error("load status set without good load");
  load_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(al_busy_ff) |-> !$past(ctrl_ff.al_dis))
    else $error("load ran while disabled");
  tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl_ff.rate != sea_pkg::SEA_RATE_TEST) |=> !tick [*8])
    else $error("memory clock enable too fast");
  addr_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == sea_pkg::SEA_ST_BIT && bidx_ff == sea_pkg::SEA_IDX_ADDR &&
     bcnt_ff == 4'h0) |-> (sh_ff == {1'b0, cyc_addr}))
    else $error("word address byte wrong");
  rd_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    (man_end && rd_ff && !nack_ff) |=> (ctrl_ff.data == $past(rx_ff)))
    else $error("read data not stored");
  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (nxt_rdy && !pwrite && sel_ctrl) |=>
      (prdata_ff[8:0] == {1'b0, $past(ctrl_ff[7:0])}))
    else $error("control word read back wrong");
  stop_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    man_end |=> !ctrl_ff.start && idle)
    else $error("start bit still set after cycle");
  sts_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|sts_set) |=> ((sts_ff & $past(sts_set)) == $past(sts_set)))
    else $error("status event lost to a clear");

endmodule : sea_nvm_port

// ### sea_pkg.sv
// Package: register map, field layout and timing for the NVM access port
package sea_pkg;

  // Register byte offsets on the APB bus
  localparam logic [11:0] SEA_OFS_CTRL = 12'h0bc;
  localparam logic [11:0] SEA_OFS_STS  = 12'h100;
  localparam logic [11:0] SEA_OFS_MSK  = 12'h104;

  // Control word reset: load disabled, rate code 01b
  localparam logic [31:0] SEA_CTRL_RST = 32'h0000_0060;

  // Rate field codes
  localparam logic [1:0] SEA_RATE_DIV  = 2'h1;
  localparam logic [1:0] SEA_RATE_TEST = 2'h3;

  // Clocking: core rate, memory clock divide ratio, phases per bit
  localparam int SEA_CORE_MHZ = 125;
  localparam int SEA_CORE_DIV = 1024;
  localparam int SEA_PHASES   = 4;

  // Serial memory bus constants
  localparam logic [6:0] SEA_DEV_ADDR = 7'h50;
  localparam logic [3:0] SEA_ACK_BIT  = 4'h8;
  localparam logic [2:0] SEA_IDX_ADDR = 3'h1;
  localparam logic [2:0] SEA_IDX_RD0  = 3'h3;
  localparam logic [2:0] SEA_IDX_WEND = 3'h3;
  localparam logic [2:0] SEA_IDX_REND = 3'h4;

  // Interrupt status bit positions
  localparam int SEA_STS_DONE = 0;
  localparam int SEA_STS_ERR  = 1;
  localparam int SEA_STS_LOAD = 2;
  localparam int SEA_STS_W    = 3;

  // Serial engine states
  typedef enum logic [1:0] {
    SEA_ST_IDLE,
    SEA_ST_START,
    SEA_ST_BIT,
    SEA_ST_STOP
  } sea_st_e;

  // Control word layout at the shared offset
  typedef struct packed {
    logic [15:0] data;
    logic [6:0]  addr;
    logic        rsv8;
    logic [1:0]  rate;
    logic        al_dis;
    logic        al_stat;
    logic        al_succ;
    logic        err;
    logic        cmd;
    logic        start;
  } sea_ctrl_s;

  // Serial memory pin drive
  typedef struct packed {
    logic scl;
    logic sda_o;
    logic sda_oe;
  } sea_pin_s;

endpackage : sea_pkg

// ### sea_tick_div.sv
// Divider: quarter-bit enable pulses for the serial memory clock
`timescale 1ns/1ns
module sea_tick_div #(
  parameter int DIV = sea_pkg::SEA_CORE_DIV
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] rate,
  // Enable out
  output logic            tick
);
  localparam int QTR = DIV / sea_pkg::SEA_PHASES;
  localparam int CW  = $clog2(QTR);

  // Ratio must split into whole quarter periods
  if (DIV < 8 || (DIV % sea_pkg::SEA_PHASES) != 0) begin : g_bad_div
    $error("divide ratio not usable");
  end

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;

  wire logic test_mode = (rate == sea_pkg::SEA_RATE_TEST);
  wire logic wrap      = (cnt_ff == CW'(QTR - 1));

  // Counter held at zero while idle so the first phase is a full quarter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= (!run || wrap) ? '0 : cnt_ff + 1'b1;
      tick_ff <= run && (test_mode || wrap);
    end
  end

  assign tick = tick_ff;

endmodule : sea_tick_div

// ### sea_mem_model.sv
// Behavioural serial memory standing behind the NVM access port
`timescale 1ns/1ns
module sea_mem_model (
  // Bus lines
  input  wire logic scl,
  input  wire logic sda,
  // Fault injection: withhold every acknowledge
  input  wire logic nack,
  // Open-drain pull on the data line
  output logic      pull_low
);
  logic [15:0] mem [128];
  logic [7:0]  sh;
  logic [7:0]  hi;
  logic [6:0]  wa    = 7'h00;
  logic [15:0] tx;
  int          bitn  = 0;
  int          byten = 0;
  logic        act   = 1'b0;
  logic        snd   = 1'b0;

  // Preload a pattern the bench can predict
  initial begin
    pull_low = 1'b0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 16'hc35a ^ (16'(i) * 16'h0101);
    end
  end

  // Start or stop: data moves while the clock is high
  always @(sda) begin
    if (scl === 1'b1) begin
      bitn  = 0;
      byten = 0;
      snd   = 1'b0;
    end
  end

  // Clock high: take one bit, or pass the acknowledge slot
  always @(posedge scl) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      if (snd) begin
        tx = {tx[14:0], 1'b1}; // Ones free the line once the word is out
      end
      bitn++;
    end else begin
      bitn = 0;
    end
  end

  // Clock low: acknowledge a received byte or present the next read bit
  always @(negedge scl) begin
    if (bitn == 8 && !snd) begin
      if (byten == 0) begin
        act = (sh[7:1] == sea_pkg::SEA_DEV_ADDR) && !nack;
        snd = act && sh[0];
        tx  = mem[wa];
      end else if (byten == 1) begin
        wa = sh[6:0];
      end else if (byten == 2) begin
        hi = sh;
      end else if (byten == 3 && act) begin
        mem[wa] = {hi, sh};
      end
      byten++;
      pull_low <= act;
    end else begin
      pull_low <= snd && bitn < 8 && !tx[15];
    end
  end
endmodule : sea_mem_model

// ### tb_sea_nvm_port.sv
// Self-checking bench for the NVM access port with a memory model
`timescale 1ns/1ns
module tb_sea_nvm_port;
  localparam logic [11:0] CTRL = sea_pkg::SEA_OFS_CTRL;
  localparam logic [11:0] STS  = sea_pkg::SEA_OFS_STS;
  localparam logic [11:0] MSK  = sea_pkg::SEA_OFS_MSK;

  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, qe, irq, nack, pull_low;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  sea_pkg::sea_pin_s mem_pin;
  logic [3:0][15:0]  cfg_words;
  int                miscompares  = 0;
  int                total_checks = 0;
  wire logic         sda_line = !(mem_pin.sda_oe || pull_low); // Pull-up

  sea_nvm_port #(.NCFG(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_pin(mem_pin),
    .sda_i(sda_line), .irq(irq), .cfg_words(cfg_words)
  );

  sea_mem_model mem_u (
    .scl(mem_pin.scl), .sda(sda_line), .nack(nack), .pull_low(pull_low)
  );

  // Core clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [15:0] pat(input int i);
    return 16'hc35a ^ (16'(i) * 16'h0101);
  endfunction : pat

  function automatic logic [31:0] ctl(input logic [15:0] d,
      input logic [6:0] a, input logic [1:0] r, input logic ds,
      input logic c, input logic s);
    return {d, a, 1'b0, r, ds, 3'h0, c, s};
  endfunction : ctl

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1); // Only the watchdog ends a hung wait
    q  = prdata;
    qe = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll until the start bit drops; bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, CTRL, 32'h0000_0000);
      n++;
    end while (q[0] !== 1'b0 && n < 12000); // No overlap of cycles
    check(32'(n < 12000), 32'h0000_0001); // Start bit self-clears
  endtask : wait_idle

  task automatic t_reset();
    check(irq, 1'b0);
    apb(1'b0, CTRL, 32'h0000_0000);
    check(q, 32'h0000_0060); // Reset word
    check(qe, 1'b0); // Mapped word answers without error
    apb(1'b0, 12'h200, 32'h0000_0000);
    check({q[30:0], qe}, 32'h0000_0001); // Unmapped refused
    $display("Test reset_values done");
  endtask : t_reset

  task automatic t_load();
    int n;
    n = 0;
    apb(1'b1, MSK, 32'h0000_0004);
    apb(1'b1, CTRL, ctl(16'h0000, 7'h00, 2'h3, 1'b0, 1'b0, 1'b0));
    do begin
      apb(1'b0, STS, 32'h0000_0000);
      n++;
    end while (q[2] !== 1'b1 && n < 2000);
    for (int i = 0; i < 4; i++) begin
      check(cfg_words[i], pat(i)); // Memory copied to config
    end
    check(irq, 1'b1); // Unmasked load event
    apb(1'b0, CTRL, 32'h0000_0000);
    check(q[4:3], 2'h3); // Both load flags set
    apb(1'b0, CTRL, 32'h0000_0000);
    check(q[4:3], 2'h2); // Read clears success only
    apb(1'b1, STS, 32'h0000_0004);
    apb(1'b1, MSK, 32'h0000_0002);
    check(irq, 1'b0); // Cleared by writing one
    $display("Test autoload done");
  endtask : t_load

  task automatic t_write();
    time t0;
    apb(1'b1, CTRL,
        ctl(16'hbeef, 7'h2a, 2'h1, 1'b1, 1'b1, 1'b1) | 32'h0000_0100);
    @(posedge mem_pin.scl);
    t0 = $time;
    @(posedge mem_pin.scl);
    check(32'(($time - t0) / 8), 32'h0000_0400); // Divide by 1024
    apb(1'b1, CTRL, 32'h0000_0000); // Dropped while running
    wait_idle();
    check(q, {16'hbeef, 7'h2a, 9'h072}); // Fields kept
    check(irq, 1'b0); // Done bit is masked
    apb(1'b0, STS, 32'h0000_0000);
    check(q[0], 1'b1); // Manual cycle done
    $display("Test slow_write done");
  endtask : t_write

  task automatic t_read();
    logic [6:0] ad [2] = '{7'h2a, 7'h09};
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, CTRL, ctl(16'h0000, ad[i], 2'h3, 1'b1, 1'b0, 1'b1));
      wait_idle();
      check(q, {(i == 0) ? 16'hbeef : pat(9), ad[i], 9'h0f0});
    end
    $display("Test reads done");
  endtask : t_read

  task automatic t_nack();
    nack <= 1'b1;
    apb(1'b1, CTRL, ctl(16'h1234, 7'h11, 2'h3, 1'b1, 1'b0, 1'b1));
    wait_idle();
    check(q, {16'h1234, 7'h11, 9'h0f4}); // Error set, data kept
    check(irq, 1'b1); // Unmasked refusal event
    apb(1'b1, STS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    nack <= 1'b0;
    apb(1'b1, CTRL, ctl(16'h5a5a, 7'h11, 2'h3, 1'b1, 1'b1, 1'b1));
    wait_idle();
    check(q[2], 1'b0); // Error cleared by next launch
    $display("Test refusal done");
  endtask : t_nack

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    nack    = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_load();
    t_write();
    t_read();
    t_nack();
    finish_test();
  end

  // Watchdog: the slow write dominates at about 40k cycles
  initial begin
    #(8 * 80000);
    miscompares++;
    finish_test();
  end
endmodule : tb_sea_nvm_port
